// ===== core/adc_pair_consts.svh
// Constants for the converter pair trigger control block.
// Assumes a 32-bit classic Wishbone slave and byte addresses.
`ifndef ADC_PAIR_CONSTS_SVH
`define ADC_PAIR_CONSTS_SVH

// Register byte offsets
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h4
`define OFS_MASK 4'h8

// Decode and generator layout
`define ADR_DEC_W 4
`define LANE_W 8
`define PWM_GEN_N 4
`define PWM_G1 0
`define PWM_G2 1
`define PWM_G4 3
`define SRC_N 13

// Control register fields
`define SEL_LSB 0
`define SEL_MSB 4
`define SOFT_BIT 5
`define PEND_BIT 6
`define IRQEN_BIT 7
`define CTRL_W 16

// Status and mask fields
`define EV_DONE 0
`define EV_START 1
`define EV_N 2

// Reset values
`define SEL_RST 5'h00
`define EV_RST 2'h0
`define DAT_RST 32'h0000_0000

// Trigger source codes
`define TRG_NONE 5'h00
`define TRG_SOFT 5'h01
`define TRG_GLOBAL 5'h02
`define TRG_SPECIAL 5'h03
`define TRG_PRI1 5'h04
`define TRG_PRI2 5'h05
`define TRG_PRI4 5'h07
`define TRG_TMR1 5'h0c
`define TRG_SEC1 5'h0e
`define TRG_SEC2 5'h0f
`define TRG_SEC4 5'h11
`define TRG_CL1 5'h17
`define TRG_CL2 5'h18
`define TRG_CL4 5'h1a
`define TRG_TMR2 5'h1f

`endif

// ===== core/adc_pair_pkg.sv
// Types for the converter pair trigger control block.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_pair_pkg;

	// Progress of one conversion of the pair
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_CONV = 2'b10
	} pair_state_t;

endpackage : adc_pair_pkg

// ===== core/adc_pair_trigger_control.sv
// Trigger selection, pending status and interrupt for one input pair.
// Assumes a classic Wishbone master and trigger pulses on clk_i.
`include "adc_pair_consts.svh"

////////////////////////////////////////////////////////////////////
module adc_pair_trigger_control #(
	parameter int ADDR_W = 4,
	parameter int PWM_N = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic tmr1_period_i,
	input wire logic tmr2_period_i,
	input wire logic special_event_i,
	input wire logic global_soft_i,
	input wire logic [PWM_N-1:0] pwm_primary_i,
	input wire logic [PWM_N-1:0] pwm_secondary_i,
	input wire logic [PWM_N-1:0] pwm_limit_i,
	input wire logic conv_busy_i,
	input wire logic conv_done_i,
	output logic conv_start_o,
	output logic pair_pending_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////
	// Parameter checks

	// Offsets decode from four address bits; generators 1, 2 and 4 sit on bits 0, 1 and 3
	generate
		if (ADDR_W < `ADR_DEC_W) begin : g_bad_addr_w
			$error("ADDR_W must be at least 4");
		end
		if (PWM_N != `PWM_GEN_N) begin : g_bad_pwm_n
			$error("PWM_N must be 4");
		end
		// Byte lane 0 alone gates writes, so every control field must sit in it
		if (`IRQEN_BIT >= `LANE_W) begin : g_bad_layout
			$error("Control fields must lie in byte lane 0");
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// Register state

	logic [4:0] pair_trigger_select;
	logic pair_soft_trigger;
	logic pair_irq_enable;
	logic [`EV_N-1:0] ev_status;
	logic [`EV_N-1:0] ev_mask;
	adc_pair_pkg::pair_state_t state;
	adc_pair_pkg::pair_state_t next_state;

	////////////////////////////////////////////////////////////////
	// Bus decode

	// Ack masks the request for a cycle, so a held strobe is taken every other cycle
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;
	wire [`ADR_DEC_W-1:0] reg_ofs = wb_adr_i[`ADR_DEC_W-1:0];
	wire hit_ctrl = (reg_ofs == `OFS_CTRL);
	wire hit_stat = (reg_ofs == `OFS_STAT);
	wire hit_mask = (reg_ofs == `OFS_MASK);
	wire wr_ctrl = bus_wr & hit_ctrl & wb_sel_i[0];
	wire wr_stat = bus_wr & hit_stat & wb_sel_i[0];
	wire wr_mask = bus_wr & hit_mask & wb_sel_i[0];

	////////////////////////////////////////////////////////////////
	// Readback

	wire pair_pending_flag = (state != adc_pair_pkg::ST_IDLE);

	wire [`CTRL_W-1:0] ctrl_view = {
		{(`CTRL_W - 8){1'b0}},
		pair_irq_enable,
		pair_pending_flag,
		pair_soft_trigger,
		pair_trigger_select
	};

	// Each register sits in the low bits of its word; the rest reads zero
	wire [31:0] ctrl_word = {{(32 - `CTRL_W){1'b0}}, ctrl_view};
	wire [31:0] stat_word = {{(32 - `EV_N){1'b0}}, ev_status};
	wire [31:0] mask_word = {{(32 - `EV_N){1'b0}}, ev_mask};

	// Unmapped offsets read as zero and still get an ack
	wire [31:0] rd_data =
		hit_ctrl ? ctrl_word :
		hit_stat ? stat_word :
		hit_mask ? mask_word :
		`DAT_RST;

	////////////////////////////////////////////////////////////////
	// Trigger source selection

	wire [4:0] sel = pair_trigger_select;

	// soft bit permitted
	// Accepted with individual or global selection alike
	wire soft_ok = pair_soft_trigger &
		((sel == `TRG_SOFT) | (sel == `TRG_GLOBAL));

	////////////////////////////////////////////////////////////////
	// Source pick table

	// One pick line per listed code; every other code picks nothing
	wire [`SRC_N-1:0] src_pick;
	wire [`SRC_N-1:0] src_event;

	assign src_pick[0] = (sel == `TRG_TMR2);
	assign src_event[0] = tmr2_period_i;
	assign src_pick[1] = (sel == `TRG_TMR1);
	assign src_event[1] = tmr1_period_i;

	assign src_pick[2] = (sel == `TRG_CL4);
	assign src_event[2] = pwm_limit_i[`PWM_G4];
	assign src_pick[3] = (sel == `TRG_CL2);
	assign src_event[3] = pwm_limit_i[`PWM_G2];
	assign src_pick[4] = (sel == `TRG_CL1);
	assign src_event[4] = pwm_limit_i[`PWM_G1];

	assign src_pick[5] = (sel == `TRG_SEC4);
	assign src_event[5] = pwm_secondary_i[`PWM_G4];
	assign src_pick[6] = (sel == `TRG_SEC2);
	assign src_event[6] = pwm_secondary_i[`PWM_G2];
	assign src_pick[7] = (sel == `TRG_SEC1);
	assign src_event[7] = pwm_secondary_i[`PWM_G1];

	assign src_pick[8] = (sel == `TRG_PRI4);
	assign src_event[8] = pwm_primary_i[`PWM_G4];
	assign src_pick[9] = (sel == `TRG_PRI2);
	assign src_event[9] = pwm_primary_i[`PWM_G2];
	assign src_pick[10] = (sel == `TRG_PRI1);
	assign src_event[10] = pwm_primary_i[`PWM_G1];

	assign src_pick[11] = (sel == `TRG_SPECIAL);
	assign src_event[11] = special_event_i;
	assign src_pick[12] = (sel == `TRG_GLOBAL);
	assign src_event[12] = global_soft_i;

	// reserved codes idle
	// Code zero and the reserved codes have no pick line, so no event gets through
	wire sel_event = |(src_pick & src_event);

	// A source held high retriggers as soon as the pair returns to idle
	wire trigger = sel_event | soft_ok;

	////////////////////////////////////////////////////////////////
	// Conversion sequence

	// Source pulses that arrive while pending or converting are dropped; a soft bit set then is kept until idle
	// pending on trigger
	wire pend_set = (state == adc_pair_pkg::ST_IDLE) & trigger;
	wire go_conv = (state == adc_pair_pkg::ST_WAIT) & ~conv_busy_i;
	// Done counts only while converting, so a stray pulse cannot end a wait
	wire done_ev = (state == adc_pair_pkg::ST_CONV) & conv_done_i;

	always_comb begin
		next_state = state;
		unique case (state)
			adc_pair_pkg::ST_IDLE: begin
				if (pend_set) begin
					next_state = adc_pair_pkg::ST_WAIT;
				end
			end
			adc_pair_pkg::ST_WAIT: begin
				if (go_conv) begin
					next_state = adc_pair_pkg::ST_CONV;
				end
			end
			adc_pair_pkg::ST_CONV: begin
				if (conv_done_i) begin
					next_state = adc_pair_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = adc_pair_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= adc_pair_pkg::ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////
	// Control register

	// A software write of one wins over the hardware clear
	// self-clearing soft bit
	wire soft_write = wr_ctrl & wb_dat_i[`SOFT_BIT];
	wire soft_keep = pair_soft_trigger & ~pend_set & ~wr_ctrl;
	wire next_soft = soft_write | soft_keep;

	wire [4:0] next_select = wr_ctrl ? wb_dat_i[`SEL_MSB:`SEL_LSB] : pair_trigger_select;
	wire next_irq_enable = wr_ctrl ? wb_dat_i[`IRQEN_BIT] : pair_irq_enable;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pair_trigger_select <= `SEL_RST;
		end else begin
			pair_trigger_select <= next_select;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pair_irq_enable <= 1'b0;
		end else begin
			pair_irq_enable <= next_irq_enable;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pair_soft_trigger <= 1'b0;
		end else begin
			pair_soft_trigger <= next_soft;
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt status, write one to clear

	wire [`EV_N-1:0] ev_in = {pend_set, done_ev & pair_irq_enable};
	wire [`EV_N-1:0] ev_clr = wr_stat ? wb_dat_i[`EV_N-1:0] : `EV_RST;
	wire [`EV_N-1:0] next_status;

	genvar gi;
	generate
		for (gi = 0; gi < `EV_N; gi++) begin : g_ev
			// New event beats a clear in the same cycle
			assign next_status[gi] = ev_in[gi] |
				(ev_status[gi] & ~ev_clr[gi]);
		end
	endgenerate

	wire [`EV_N-1:0] next_mask = wr_mask ? wb_dat_i[`EV_N-1:0] : ev_mask;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_status <= `EV_RST;
		end else begin
			ev_status <= next_status;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_mask <= `EV_RST;
		end else begin
			ev_mask <= next_mask;
		end
	end

	////////////////////////////////////////////////////////////////
	// Request output

	// request output
	// Built from the next values so irq_o rises with the status bit, not a cycle later
	wire next_irq = |(next_status & next_mask);

	////////////////////////////////////////////////////////////////
	// Registered outputs

	// Read data is zero outside the ack cycle so a late sample sees nothing stale
	wire [31:0] next_dat = bus_req ? rd_data : `DAT_RST;
	wire next_pending = (next_state != adc_pair_pkg::ST_IDLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `DAT_RST;
		end else begin
			wb_ack_o <= bus_req;
			wb_dat_o <= next_dat;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_start_o <= 1'b0;
		end else begin
			conv_start_o <= go_conv;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pair_pending_o <= 1'b0;
		end else begin
			pair_pending_o <= next_pending;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= next_irq;
		end
	end

endmodule : adc_pair_trigger_control

// ===== tb/adc_pair_trigger_control_asserts.sv
// Port checker for the pair trigger control block.
// Assumes a bind onto every instance of the top module.
module adc_pair_trigger_control_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic conv_busy_i,
	input wire logic conv_done_i,
	input wire logic conv_start_o,
	input wire logic pair_pending_o,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_next_cycle_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked");
	ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	start_after_pend_a: assert property (
		conv_start_o |-> $past(pair_pending_o) && !$past(conv_busy_i))
		else $error("start without free pending");
	start_one_pulse_a: assert property (conv_start_o |=> !conv_start_o)
		else $error("start too long");
	busy_defers_a: assert property (pair_pending_o && conv_busy_i |=> !conv_start_o)
		else $error("start while busy");
	prompt_start_a: assert property ($rose(pair_pending_o) && !conv_busy_i |=> conv_start_o)
		else $error("start late");
	pend_clear_done_a: assert property ($fell(pair_pending_o) |-> $past(conv_done_i))
		else $error("pending fell early");
	pend_stays_a: assert property (pair_pending_o && !conv_done_i |=> pair_pending_o)
		else $error("pending lost");
	cover property (conv_start_o);
	cover property (pair_pending_o && conv_busy_i);
	cover property (irq_o);
endmodule : adc_pair_trigger_control_asserts

bind adc_pair_trigger_control adc_pair_trigger_control_asserts chk (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_ack_o, .conv_busy_i, .conv_done_i, .conv_start_o, .pair_pending_o, .irq_o);

// ===== tb/converter_model.sv
// Converter model: busy for LAT cycles after a start, then a done pulse.
// Assumes start pulses on clk_i; hold_i adds outside busy time.
module converter_model #(
	parameter int LAT = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic hold_i,
	output logic busy_o,
	output logic done_o
);
	logic [3:0] cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 4'h0;
			done_o <= 1'h0;
		end else begin
			done_o <= (cnt == 4'h1);
			cnt <= start_i ? 4'(LAT) : cnt - 4'((cnt != 4'h0));
		end
	end
	assign busy_o = hold_i || (cnt != 4'h0);
endmodule : converter_model

// ===== tb/adc_pair_trigger_control_tb.sv
// Self-checking bench for the pair trigger control block.
// Assumes the converter model and the bound checker.
module adc_pair_trigger_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, hold = 0;
	logic [3:0] wb_adr_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic wb_ack_o, conv_busy_i, conv_done_i, conv_start_o, pair_pending_o, irq_o;
	logic [15:0] ev = 16'h0;
	int n_mismatch = 0, tests_run = 0;
	logic [4:0] code [13] = '{5'h0c, 5'h1f, 5'h03, 5'h02, 5'h04, 5'h05, 5'h07, 5'h0e, 5'h0f,
		5'h11, 5'h17, 5'h18, 5'h1a};
	int bitn [13] = '{0, 1, 2, 3, 4, 5, 7, 8, 9, 11, 12, 13, 15};
	adc_pair_trigger_control uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .tmr1_period_i(ev[0]),
		.tmr2_period_i(ev[1]), .special_event_i(ev[2]), .global_soft_i(ev[3]),
		.pwm_primary_i(ev[7:4]), .pwm_secondary_i(ev[11:8]), .pwm_limit_i(ev[15:12]),
		.conv_busy_i, .conv_done_i, .conv_start_o, .pair_pending_o, .irq_o);
	converter_model conv (.clk_i, .rst_i, .start_i(conv_start_o), .hold_i(hold),
		.busy_o(conv_busy_i), .done_o(conv_done_i));
	initial forever #10 clk_i = ~clk_i;
	initial begin
		repeat (5000) @(posedge clk_i);
		n_mismatch++;
		give_verdict();
	end
	////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		{wb_cyc_i, wb_stb_i} <= 2'h0;
	endtask : wb
	task pulse(input logic [15:0] v);
		@(posedge clk_i);
		ev <= v;
		@(posedge clk_i);
		ev <= 16'h0;
		@(negedge clk_i);
	endtask : pulse
	task settle;
		for (int i = 0; i < 40 && pair_pending_o !== 1'h0; i++) @(negedge clk_i);
	endtask : settle
	task give_verdict;
		$display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(1'h1, 4'h8, 32'h1);
		wb(1'h1, 4'h0, 32'h8c);
		pulse(16'h1);
		chk("pending", 32'h1, 32'(pair_pending_o));
		settle();
		chk("irq", 32'h1, 32'(irq_o));
		wb(1'h0, 4'h0, 32'h0);
		chk("ctrl", 32'h8c, q);
		wb(1'h0, 4'h4, 32'h0);
		chk("status", 32'h3, q);
		wb(1'h1, 4'h4, 32'h3);
		repeat (2) @(negedge clk_i);
		chk("irq", 32'h0, 32'(irq_o));
		for (int i = 0; i < 13; i++) begin
			wb(1'h1, 4'h0, 32'(code[i]));
			pulse(~(16'h1 << bitn[i]));
			chk("table other", 32'h0, 32'(pair_pending_o));
			pulse(16'h1 << bitn[i]);
			chk("table pending", 32'h1, 32'(pair_pending_o));
			settle();
		end
		chk("irq", 32'h0, 32'(irq_o));
		for (int i = 0; i < 2; i++) begin
			wb(1'h1, 4'h0, i ? 32'h1b : 32'h0);
			pulse(16'hffff);
			chk("idle pending", 32'h0, 32'(pair_pending_o));
		end
		for (int i = 1; i < 3; i++) begin
			wb(1'h1, 4'h0, 32'(i));
			wb(1'h1, 4'h0, 32'h20 | 32'(i));
			repeat (2) @(negedge clk_i);
			chk("soft pending", 32'h1, 32'(pair_pending_o));
			settle();
			wb(1'h0, 4'h0, 32'h0);
			chk("soft clear", 32'(i), q);
		end
		@(posedge clk_i);
		hold <= 1'h1;
		wb(1'h1, 4'h0, 32'hc);
		pulse(16'h1);
		repeat (6) @(negedge clk_i);
		chk("held pending", 32'h1, 32'(pair_pending_o));
		@(posedge clk_i);
		hold <= 1'h0;
		settle();
		chk("late pending", 32'h0, 32'(pair_pending_o));
		wb(1'h0, 4'hc, 32'h0);
		chk("unmapped", 32'h0, q);
		give_verdict();
	end
endmodule : adc_pair_trigger_control_tb
